//--- core/smie_pkg.sv
package smie_pkg;
   // edge detector reset level: request line idles high
   localparam logic REQ_IDLE_LEVEL = 1'b1;
   // mode-active output reset level: inactive high
   localparam logic MODE_OUT_RESET = 1'b1;
   // one-hot entry sequencer codes
   typedef enum logic [2:0] {
      SMIE_RUN = 3'b001,
      SMIE_ENTER = 3'b010,
      SMIE_MGMT = 3'b100
   } smie_state_type;
endpackage

//--- core/smie_edge_latch.sv
`timescale 1ns/100ps
// falling-edge capture of the active-low request with a pending latch
module smie_edge_latch
   import smie_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic reqN,
   input wire logic clearPend,
   output logic pending
);
   logic reqPrev_r; // last sampled request level
   logic reqPrev_nxt;
   logic pend_r; // sticky pending flag
   logic pend_nxt;
   logic fallEdge; // high-to-low seen this cycle

   // next-state: a new edge wins over a same-cycle clear so no request is lost
   always_comb begin
      reqPrev_nxt = reqN;
      fallEdge = reqPrev_r & ~reqN;
      pend_nxt = pend_r;
      if (clearPend) begin
         pend_nxt = 1'b0;
      end
      if (fallEdge) begin
         pend_nxt = 1'b1;
      end
   end

   // registers only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reqPrev_r <= REQ_IDLE_LEVEL;
         pend_r <= 1'b0;
      end else begin
         reqPrev_r <= reqPrev_nxt;
         pend_r <= pend_nxt;
      end
   end

   assign pending = pend_r;

   // a falling edge always leaves the latch set next cycle
   edge_sets_pend_a: assert property (@(posedge core_clk) disable iff (rst)
      (reqPrev_r && !reqN) |=> pend_r)
      else $error("falling edge did not set pending");
   // a steady low level never creates a request by itself
   level_no_pend_a: assert property (@(posedge core_clk) disable iff (rst)
      (!pend_r && !reqPrev_r && !clearPend) |=> !pend_r)
      else $error("pending set without a falling edge");
endmodule // smie_edge_latch

//--- core/smie_entry.sv
`timescale 1ns/100ps
// Summary of operation
// - latch request on its falling edge
// - management request outranks other external interrupts
// - finish current instruction, then enter mode
// - sample at boundaries and string iterations
// - never enter inside locked cycles or mode
// - capture new edges while in mode
// - held request served only after resume
// - mode output low from entry to resume
module smie_entry
   import smie_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mgmtInterruptReqN,
   input wire logic instrBoundary,
   input wire logic stringIterBoundary,
   input wire logic lockedCycle,
   input wire logic extIntReq,
   input wire logic resumeFromMgmtInstruction,
   input wire logic entryDone,
   output logic mgmtModeActiveN,
   output logic mgmtEntryStart,
   output logic extIntTake,
   output logic mgmtPending
);
   // interface notes:
   // - the request pin is treated as synchronous; a falling edge is a high
   //   sample followed by a low sample on the next edge
   // - entry is only decided at a legal slot: an instruction boundary or a
   //   gap between string iterations, outside a locked bus sequence
   // - entryDone comes from the core once state saving is finished; the
   //   resume pulse is ignored until that has happened
   // - every output is a flip-flop, so decisions show one cycle later
   // - a second request arriving in the mode stays pending and waits
   //   for the first slot after the resume
   // - the grant for the ordinary interrupt path stays high as long as the request and an open slot last in the run state with no management request waiting;
   //   the core is expected to pick it up in that same cycle

   smie_state_type state_r; // entry sequencer
   smie_state_type state_nxt;
   logic modeN_r; // active-low mode output
   logic modeN_nxt;
   logic start_r; // one-cycle entry strobe
   logic start_nxt;
   logic extTake_r; // other interrupt granted
   logic extTake_nxt;
   logic pendQ_r; // registered pending view
   logic pend; // pending from edge latch
   logic takeSlot; // a legal sampling point
   logic takeMgmt; // entry decision this cycle

   // state decode shared by both decision paths
   function automatic logic isRun(input smie_state_type s);
      return s == SMIE_RUN;
   endfunction

   // legal slot decode, shared by entry and the ordinary grant
   function automatic logic slotOpen(input logic instrB, input logic iterB, input logic locked);
      return (instrB | iterB) & ~locked;
   endfunction

   // pending capture keeps running in every state
   smie_edge_latch u_latch (
      .core_clk(core_clk),
      .rst(rst),
      .reqN(mgmtInterruptReqN),
      .clearPend(takeMgmt),
      .pending(pend)
   );

   // decision: only at boundaries, outside locked cycles and outside the mode
   always_comb begin
      takeSlot = slotOpen(instrBoundary, stringIterBoundary, lockedCycle);
      takeMgmt = pend & takeSlot & isRun(state_r);
      state_nxt = state_r;
      modeN_nxt = modeN_r;
      start_nxt = 1'b0;
      unique case (state_r)
         SMIE_RUN: begin
            if (takeMgmt) begin
               state_nxt = SMIE_ENTER;
               modeN_nxt = 1'b0;
               start_nxt = 1'b1;
            end
         end
         SMIE_ENTER: begin
            // wait for the core to finish saving state
            if (entryDone) begin
               state_nxt = SMIE_MGMT;
            end
         end
         SMIE_MGMT: begin
            // resume ends the mode; held request waits for the next slot
            if (resumeFromMgmtInstruction) begin
               state_nxt = SMIE_RUN;
               modeN_nxt = 1'b1;
            end
         end
      endcase
   end

   // sequencer registers only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_r <= SMIE_RUN;
         modeN_r <= MODE_OUT_RESET;
         start_r <= 1'b0;
         pendQ_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         modeN_r <= modeN_nxt;
         start_r <= start_nxt;
         pendQ_r <= pend;
      end
   end

   // ordinary interrupt grant: only when no management request waits
   // a waiting management request blocks the grant even at an open slot,
   // which costs a little latency but keeps the ordering simple
   always_comb begin
      extTake_nxt = extIntReq & takeSlot & ~pend & isRun(state_r);
   end

   // grant register only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         extTake_r <= 1'b0;
      end else begin
         extTake_r <= extTake_nxt;
      end
   end

   assign mgmtModeActiveN = modeN_r;
   assign mgmtEntryStart = start_r;
   assign extIntTake = extTake_r;
   assign mgmtPending = pendQ_r;

   // entry strobe only follows a boundary of either kind
   entry_needs_slot_a: assert property (@(posedge core_clk) disable iff (rst)
      start_r |-> $past(instrBoundary) || $past(stringIterBoundary))
      else $error("entry outside a boundary");

   // a locked sequence must never be split by entry
   no_locked_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      start_r |-> !$past(lockedCycle))
      else $error("entry during locked cycles");

   // the mode output falls together with the entry strobe
   entry_drives_low_a: assert property (@(posedge core_clk) disable iff (rst)
      start_r |-> !modeN_r && $past(modeN_r))
      else $error("mode output not asserted at entry");

   // in the mode the output stays low until resume
   mode_held_low_a: assert property (@(posedge core_clk) disable iff (rst)
      (!modeN_r && !resumeFromMgmtInstruction && state_r == SMIE_MGMT) |=> !modeN_r)
      else $error("mode output released without resume");

   // no second entry while the output is still low
   no_reentry_a: assert property (@(posedge core_clk) disable iff (rst)
      $past(!modeN_r) |-> !start_r)
      else $error("entry while already in mode");

   // the ordinary grant never passes a waiting request
   mgmt_priority_a: assert property (@(posedge core_clk) disable iff (rst)
      extTake_r |-> !$past(pend))
      else $error("other interrupt taken over pending request");

   // entry empties the latch unless a fresh edge lands in that cycle
   entry_clears_a: assert property (@(posedge core_clk) disable iff (rst)
      (takeMgmt && mgmtInterruptReqN) |=> !pend)
      else $error("pending not cleared at entry");

   // a waiting request is taken at the first open slot
   pend_served_a: assert property (@(posedge core_clk) disable iff (rst)
      (pend && takeSlot && state_r == SMIE_RUN) |=> start_r ##0 !modeN_r)
      else $error("pending request not taken at slot");

   // the entry strobe is a single cycle wide
   start_single_a: assert property (@(posedge core_clk) disable iff (rst)
      start_r |=> !start_r)
      else $error("entry strobe longer than one cycle");

   // while state is being saved the output is already low
   enter_keeps_low_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SMIE_ENTER) |-> !modeN_r)
      else $error("mode output high during entry");

   // resume in the mode releases the output on the next edge
   resume_releases_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_r == SMIE_MGMT && resumeFromMgmtInstruction) |=> modeN_r && state_r == SMIE_RUN)
      else $error("resume did not leave the mode");

   // a held request is never started from outside the run state
   held_waits_a: assert property (@(posedge core_clk) disable iff (rst)
      (state_r != SMIE_RUN) |=> !start_r)
      else $error("entry started outside the run state");

   // the mode output only falls as part of an entry
   fall_needs_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(modeN_r) |-> start_r)
      else $error("mode output fell without entry");

   // the ordinary grant also needs an open slot
   ext_needs_slot_a: assert property (@(posedge core_clk) disable iff (rst)
      extTake_r |-> $past(takeSlot))
      else $error("other interrupt granted outside a slot");
endmodule // smie_entry

//--- verification/smie_req_model.sv
`timescale 1ns/100ps
// far-side request source: pulls the request line low while asked
module smie_req_model (
   input wire logic core_clk,
   input wire logic fire,
   output logic reqN
);
   // line rests high on its pull-up between requests
   initial reqN = 1'b1;
   // a high-to-low step is what the core latches, so each fire makes one
   always @(posedge core_clk) begin
      reqN <= ~fire;
   end
endmodule // smie_req_model

//--- verification/test_system_mgmt_interrupt_entry.sv
`timescale 1ns/100ps
module test_system_mgmt_interrupt_entry;
   import smie_pkg::*;
   logic core_clk = 0, rst = 1, fire = 0, instrBoundary = 0, stringIterBoundary = 0;
   logic lockedCycle = 0, extIntReq = 0, resumeFromMgmtInstruction = 0, entryDone = 0;
   logic mgmtInterruptReqN, mgmtModeActiveN, mgmtEntryStart, extIntTake, mgmtPending;
   int errors = 0, checked = 0;
   bit seen;
   always #5 core_clk = ~core_clk;
   smie_req_model i_req (.core_clk(core_clk), .fire(fire), .reqN(mgmtInterruptReqN));
   smie_entry i_dut (.core_clk(core_clk), .rst(rst), .mgmtInterruptReqN(mgmtInterruptReqN),
      .instrBoundary(instrBoundary), .stringIterBoundary(stringIterBoundary),
      .lockedCycle(lockedCycle), .extIntReq(extIntReq),
      .resumeFromMgmtInstruction(resumeFromMgmtInstruction), .entryDone(entryDone),
      .mgmtModeActiveN(mgmtModeActiveN), .mgmtEntryStart(mgmtEntryStart),
      .extIntTake(extIntTake), .mgmtPending(mgmtPending));
   // one comparison, counted
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // watch a bounded span for the entry pulse
   task automatic waitStart(output bit s);
      s = 0;
      repeat (6) begin
         @(negedge core_clk);
         if (mgmtEntryStart === 1'b1) s = 1;
      end
   endtask
   // two cycles of low level, then back to idle
   task automatic request();
      fire = 1;
      cyc(2);
      fire = 0;
   endtask
   task automatic finish_test();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard: tests need about 45 cycles, guard allows 10000
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   task automatic t_reset();
      cyc(5);
      rst = 0;
      chk(mgmtModeActiveN === 1'b1 && mgmtPending === 1'b0, "reset state");
   endtask
   task automatic t_capture();
      request();
      cyc(1);
      chk(mgmtPending === 1'b1, "edge not latched");
   endtask
   task automatic t_wait_other();
      extIntReq = 1;
      cyc(3);
      chk(extIntTake === 1'b0, "other interrupt beat pending");
      extIntReq = 0;
   endtask
   // boundary inside a locked sequence must not enter
   task automatic t_locked();
      lockedCycle = 1;
      instrBoundary = 1;
      waitStart(seen);
      chk(!seen && mgmtModeActiveN === 1'b1, "entered in locked cycle");
   endtask
   // slot opens with both requests present: management wins
   task automatic t_entry();
      lockedCycle = 0;
      extIntReq = 1;
      cyc(1);
      chk(mgmtEntryStart === 1'b1 && extIntTake === 1'b0, "slot contest lost");
      extIntReq = 0;
      cyc(1);
      chk(mgmtEntryStart === 1'b0 && mgmtModeActiveN === 1'b0, "entry pulse wrong");
      cyc(1);
      chk(mgmtPending === 1'b0, "pending not cleared");
   endtask
   // second request while in mode: held, not served
   task automatic t_inmode();
      request();
      waitStart(seen);
      chk(!seen && mgmtPending === 1'b1, "in-mode request mishandled");
      entryDone = 1;
      cyc(1);
      entryDone = 0;
      cyc(2);
      chk(mgmtModeActiveN === 1'b0, "mode output left early");
   endtask
   task automatic t_resume();
      instrBoundary = 0;
      stringIterBoundary = 1;
      resumeFromMgmtInstruction = 1;
      cyc(1);
      resumeFromMgmtInstruction = 0;
      chk(mgmtModeActiveN === 1'b1, "mode output kept after resume");
      waitStart(seen);
      chk(seen, "held request not served");
      entryDone = 1;
      cyc(1);
      entryDone = 0;
      stringIterBoundary = 0;
      resumeFromMgmtInstruction = 1;
      cyc(1);
      resumeFromMgmtInstruction = 0;
      cyc(2);
      chk(mgmtPending === 1'b0 && mgmtModeActiveN === 1'b1, "not idle");
   endtask
   // no management request waits: the ordinary grant pulses once
   task automatic t_ext_grant();
      extIntReq = 1;
      instrBoundary = 1;
      cyc(1);
      chk(extIntTake === 1'b1, "other interrupt not granted");
      extIntReq = 0;
      instrBoundary = 0;
      cyc(1);
      chk(extIntTake === 1'b0, "grant longer than one cycle");
   endtask
   initial begin
      t_reset();
      t_capture();
      t_wait_other();
      t_locked();
      t_entry();
      t_inmode();
      t_resume();
      t_ext_grant();
      finish_test();
   end
endmodule // test_system_mgmt_interrupt_entry
